// *** rtl/aewb_limits.v ***
// Auto exposure and white balance limit, metering and selection logic.
// Assumes the pixel stream, loop requests and register port share
// clock_in; pixels are linear (before gamma).
//
// Operation
// - Programmed exposure time never below the exposure minimum (us).
// - Programmed exposure time never above the exposure maximum (us).
// - Programmed gain never below the gain minimum (dB).
// - Programmed gain never above the gain maximum (dB).
// - Target mean never below the minimum grey percentage.
// - Red and blue ratios set no lower than the ratio minimum at each frame end with the white balance loop on.
// - Red and blue ratios set no higher than the ratio maximum at each frame end with the white balance loop on.
// - Larger damping gives smaller, slower ratio steps.
// - Profile selector picks indoor or outdoor white balance goals.
// - Target source: off uses user value, continuous uses a fixed internal value (50).
// - Mean compared against target in linear pixel domain.
// - Manual target value is a percent of full scale.
// - Lighting selector has four values, normal after reset.
// - Metering selection only applies under normal lighting.
// - Average metering weights every pixel equally.
// - Spot metering measures central ~3 percent only.
// - Partial metering measures central ~11 percent.
// - Metering selector encodes five choices.
// - Region height held per algorithm, written to selected one.
// - Algorithm selector addresses white balance or exposure.
// - Target mean never above the maximum grey percentage.
`default_nettype none
`include "aewb_map.vh"

module aewb_limits (
  input wire clock_in,
  input wire reset_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output wire [31:0] reg_rdata_out,
  input wire [`AEWB_EXP_W-1:0] exp_request_in,
  input wire [`AEWB_GAIN_W-1:0] gain_request_in,
  input wire pixel_valid_in,
  input wire [7:0] pixel_in,
  input wire [`AEWB_POS_W-1:0] pixel_x_in,
  input wire [`AEWB_POS_W-1:0] pixel_y_in,
  input wire frame_end_in,
  input wire [`AEWB_RATIO_W-1:0] wb_indoor_red_in,
  input wire [`AEWB_RATIO_W-1:0] wb_indoor_blue_in,
  input wire [`AEWB_RATIO_W-1:0] wb_outdoor_red_in,
  input wire [`AEWB_RATIO_W-1:0] wb_outdoor_blue_in,
  output wire [`AEWB_EXP_W-1:0] exposure_out,
  output wire [`AEWB_GAIN_W-1:0] gain_out,
  output wire [`AEWB_PCT_W-1:0] target_mean_out,
  output reg brighter_out,
  output reg darker_out,
  output wire [`AEWB_RATIO_W-1:0] red_ratio_out,
  output wire [`AEWB_RATIO_W-1:0] blue_ratio_out,
  output reg [`AEWB_HEIGHT_W-1:0] ae_region_height_out,
  output reg [`AEWB_HEIGHT_W-1:0] wb_region_height_out
);

  // Configuration registers
  reg auto_wb_loop_q;
  reg target_mean_source_q;
  reg wb_profile_select_q;
  reg algo_target_select_q;
  reg [1:0] lighting_select_q;
  reg [2:0] metering_select_q;
  reg [`AEWB_EXP_W-1:0] exp_min_q;
  reg [`AEWB_EXP_W-1:0] exp_max_q;
  reg [`AEWB_GAIN_W-1:0] ae_gain_min_q;
  reg [`AEWB_GAIN_W-1:0] ae_gain_max_q;
  reg [`AEWB_PCT_W-1:0] target_mean_min_q;
  reg [`AEWB_PCT_W-1:0] target_mean_max_q;
  reg [`AEWB_PCT_W-1:0] target_mean_value_q;
  reg [`AEWB_RATIO_W-1:0] wb_ratio_min_q;
  reg [`AEWB_RATIO_W-1:0] wb_ratio_max_q;
  reg [2:0] wb_step_damping_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // Metering state
  reg [2:0] meter_eff;
  reg in_spot;
  reg in_part;
  reg [1:0] weight;
  reg [27:0] sum_q;
  reg [19:0] count_q;
  reg [18:0] bin_q [0:3];
  reg [1:0] peak_bin;
  reg [7:0] peak_level;
  reg [39:0] lhs;
  reg [39:0] rhs;
  reg [`AEWB_PCT_W-1:0] target_raw;

  wire [`AEWB_PCT_W-1:0] target_mean;
  wire [`AEWB_RATIO_W-1:0] red_q;
  wire [`AEWB_RATIO_W-1:0] blue_q;
  reg [`AEWB_RATIO_W-1:0] red_goal;
  reg [`AEWB_RATIO_W-1:0] blue_goal;
  wire [`AEWB_RATIO_W-1:0] red_next;
  wire [`AEWB_RATIO_W-1:0] blue_next;
  wire wr_hit;

  assign wr_hit = reg_write_in;

  // Register writes
  always @(posedge clock_in) begin
    if (reset_in) begin
      auto_wb_loop_q <= 1'b0;
      target_mean_source_q <= 1'b0;
      wb_profile_select_q <= 1'b0;
      algo_target_select_q <= 1'b0;
      lighting_select_q <= `AEWB_LIGHT_NORMAL;
      metering_select_q <= `AEWB_METER_AVERAGE;
      exp_min_q <= `AEWB_RST_EXP_MIN;
      exp_max_q <= `AEWB_RST_EXP_MAX;
      ae_gain_min_q <= `AEWB_RST_GAIN_MIN;
      ae_gain_max_q <= `AEWB_RST_GAIN_MAX;
      target_mean_min_q <= `AEWB_RST_TMEAN_MIN;
      target_mean_max_q <= `AEWB_RST_TMEAN_MAX;
      target_mean_value_q <= `AEWB_RST_TMEAN_VALUE;
      wb_ratio_min_q <= `AEWB_RST_WB_MIN;
      wb_ratio_max_q <= `AEWB_RST_WB_MAX;
      wb_step_damping_q <= `AEWB_RST_WB_DAMP;
      ae_region_height_out <= `AEWB_RST_REGION_H;
      wb_region_height_out <= `AEWB_RST_REGION_H;
    end else if (wr_hit) begin
      case (reg_addr_in)
        `AEWB_REG_CTRL: begin
          auto_wb_loop_q <= reg_wdata_in[`AEWB_CTRL_WB_ENABLE];
          target_mean_source_q <= reg_wdata_in[`AEWB_CTRL_TMEAN_SRC];
          wb_profile_select_q <= reg_wdata_in[`AEWB_CTRL_PROFILE];
          algo_target_select_q <= reg_wdata_in[`AEWB_CTRL_ALGO_SEL];
        end
        `AEWB_REG_LIGHTING: begin
          lighting_select_q <= reg_wdata_in[1:0];
        end
        `AEWB_REG_METERING: begin
          // Codes above five choices are refused
          if (reg_wdata_in[2:0] <= `AEWB_METER_HIST) begin
            metering_select_q <= reg_wdata_in[2:0];
          end
        end
        `AEWB_REG_EXP_MIN: exp_min_q <= reg_wdata_in[`AEWB_EXP_W-1:0];
        `AEWB_REG_EXP_MAX: exp_max_q <= reg_wdata_in[`AEWB_EXP_W-1:0];
        `AEWB_REG_GAIN_MIN: begin
          ae_gain_min_q <= reg_wdata_in[`AEWB_GAIN_W-1:0];
        end
        `AEWB_REG_GAIN_MAX: begin
          ae_gain_max_q <= reg_wdata_in[`AEWB_GAIN_W-1:0];
        end
        `AEWB_REG_TMEAN_MIN: begin
          target_mean_min_q <= reg_wdata_in[`AEWB_PCT_W-1:0];
        end
        `AEWB_REG_TMEAN_MAX: begin
          target_mean_max_q <= reg_wdata_in[`AEWB_PCT_W-1:0];
        end
        `AEWB_REG_TMEAN_VALUE: begin
          target_mean_value_q <= reg_wdata_in[`AEWB_PCT_W-1:0];
        end
        `AEWB_REG_WB_MIN: begin
          wb_ratio_min_q <= reg_wdata_in[`AEWB_RATIO_W-1:0];
        end
        `AEWB_REG_WB_MAX: begin
          wb_ratio_max_q <= reg_wdata_in[`AEWB_RATIO_W-1:0];
        end
        `AEWB_REG_WB_DAMP: wb_step_damping_q <= reg_wdata_in[2:0];
        `AEWB_REG_REGION_H: begin
          if (algo_target_select_q) begin
            ae_region_height_out <= reg_wdata_in[`AEWB_HEIGHT_W-1:0];
          end else begin
            wb_region_height_out <= reg_wdata_in[`AEWB_HEIGHT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads, data in the cycle after the strobe
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr_in)
      `AEWB_REG_CTRL: begin
        rdata_d[`AEWB_CTRL_WB_ENABLE] = auto_wb_loop_q;
        rdata_d[`AEWB_CTRL_TMEAN_SRC] = target_mean_source_q;
        rdata_d[`AEWB_CTRL_PROFILE] = wb_profile_select_q;
        rdata_d[`AEWB_CTRL_ALGO_SEL] = algo_target_select_q;
      end
      `AEWB_REG_LIGHTING: rdata_d[1:0] = lighting_select_q;
      `AEWB_REG_METERING: rdata_d[2:0] = metering_select_q;
      `AEWB_REG_EXP_MIN: rdata_d[`AEWB_EXP_W-1:0] = exp_min_q;
      `AEWB_REG_EXP_MAX: rdata_d[`AEWB_EXP_W-1:0] = exp_max_q;
      `AEWB_REG_GAIN_MIN: rdata_d[`AEWB_GAIN_W-1:0] = ae_gain_min_q;
      `AEWB_REG_GAIN_MAX: rdata_d[`AEWB_GAIN_W-1:0] = ae_gain_max_q;
      `AEWB_REG_TMEAN_MIN: rdata_d[`AEWB_PCT_W-1:0] = target_mean_min_q;
      `AEWB_REG_TMEAN_MAX: rdata_d[`AEWB_PCT_W-1:0] = target_mean_max_q;
      `AEWB_REG_TMEAN_VALUE: begin
        rdata_d[`AEWB_PCT_W-1:0] = target_mean_value_q;
      end
      `AEWB_REG_WB_MIN: rdata_d[`AEWB_RATIO_W-1:0] = wb_ratio_min_q;
      `AEWB_REG_WB_MAX: rdata_d[`AEWB_RATIO_W-1:0] = wb_ratio_max_q;
      `AEWB_REG_WB_DAMP: rdata_d[2:0] = wb_step_damping_q;
      `AEWB_REG_REGION_H: begin
        rdata_d[`AEWB_HEIGHT_W-1:0] = algo_target_select_q ?
          ae_region_height_out : wb_region_height_out;
      end
      `AEWB_REG_STATUS: begin
        rdata_d[0] = brighter_out;
        rdata_d[1] = darker_out;
        rdata_d[6:4] = meter_eff;
        rdata_d[14:8] = target_mean;
      end
      `AEWB_REG_EXPOSURE: rdata_d[`AEWB_EXP_W-1:0] = exposure_out;
      `AEWB_REG_GAIN: rdata_d[`AEWB_GAIN_W-1:0] = gain_out;
      `AEWB_REG_WB_RATIO: begin
        rdata_d[`AEWB_RATIO_W-1:0] = red_q;
        rdata_d[16+`AEWB_RATIO_W-1:16] = blue_q;
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      rdata_q <= 32'h00000000;
    end else if (reg_read_in) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata_out = rdata_q;

  // Exposure and gain limits
  aewb_clamp #(
    .WIDTH(`AEWB_EXP_W),
    .RESET_VALUE(`AEWB_RST_EXP_MIN)
  ) u_exp_clamp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(1'b1),
    .value_in(exp_request_in),
    .lo_in(exp_min_q),
    .hi_in(exp_max_q),
    .value_out(exposure_out)
  );

  aewb_clamp #(
    .WIDTH(`AEWB_GAIN_W),
    .RESET_VALUE(`AEWB_RST_GAIN_MIN)
  ) u_gain_clamp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(1'b1),
    .value_in(gain_request_in),
    .lo_in(ae_gain_min_q),
    .hi_in(ae_gain_max_q),
    .value_out(gain_out)
  );

  // Target mean: user value when off, internal choice when continuous
  always @* begin
    if (target_mean_source_q) begin
      target_raw = `AEWB_RST_TMEAN_AUTO;
    end else begin
      target_raw = target_mean_value_q;
    end
  end

  aewb_clamp #(
    .WIDTH(`AEWB_PCT_W),
    .RESET_VALUE(`AEWB_RST_TMEAN_VALUE)
  ) u_target_clamp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(1'b1),
    .value_in(target_raw),
    .lo_in(target_mean_min_q),
    .hi_in(target_mean_max_q),
    .value_out(target_mean)
  );

  assign target_mean_out = target_mean;

  // Non-normal lighting overrides metering with a fixed pattern
  always @* begin
    case (lighting_select_q)
      `AEWB_LIGHT_NORMAL: meter_eff = metering_select_q;
      `AEWB_LIGHT_BACK: meter_eff = `AEWB_METER_CENTER;
      `AEWB_LIGHT_FRONT: meter_eff = `AEWB_METER_PARTIAL;
      default: meter_eff = `AEWB_METER_AVERAGE;
    endcase
  end

  always @* begin
    in_spot = (pixel_x_in >= `AEWB_SPOT_X_LO) &&
      (pixel_x_in <= `AEWB_SPOT_X_HI) &&
      (pixel_y_in >= `AEWB_SPOT_Y_LO) && (pixel_y_in <= `AEWB_SPOT_Y_HI);
    in_part = (pixel_x_in >= `AEWB_PART_X_LO) &&
      (pixel_x_in <= `AEWB_PART_X_HI) &&
      (pixel_y_in >= `AEWB_PART_Y_LO) && (pixel_y_in <= `AEWB_PART_Y_HI);
    case (meter_eff)
      `AEWB_METER_SPOT: weight = {1'b0, in_spot};
      `AEWB_METER_PARTIAL: weight = {1'b0, in_part};
      `AEWB_METER_CENTER: weight = in_part ? 2'h2 : 2'h1;
      default: weight = 2'h1;
    endcase
  end

  // Scene accumulation over one frame
  always @(posedge clock_in) begin
    if (reset_in || frame_end_in) begin
      sum_q <= 28'h0000000;
      count_q <= 20'h00000;
    end else if (pixel_valid_in) begin
      sum_q <= sum_q + {18'h00000, pixel_in, 2'h0} * weight / 28'd4;
      count_q <= count_q + {18'h00000, weight};
    end
  end

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bin
      always @(posedge clock_in) begin
        if (reset_in || frame_end_in) begin
          bin_q[b] <= 19'h00000;
        end else if (pixel_valid_in && pixel_in[7:6] == b) begin
          bin_q[b] <= bin_q[b] + 19'h00001;
        end
      end
    end
  endgenerate

  always @* begin
    peak_bin = 2'h0;
    if (bin_q[1] > bin_q[peak_bin]) peak_bin = 2'h1;
    if (bin_q[2] > bin_q[peak_bin]) peak_bin = 2'h2;
    if (bin_q[3] > bin_q[peak_bin]) peak_bin = 2'h3;
    peak_level = {peak_bin, 6'h20};
  end

  // Cross-multiplied compare avoids a divider; both sides linear codes
  always @* begin
    if (meter_eff == `AEWB_METER_HIST) begin
      lhs = {32'h00000000, peak_level} * `AEWB_PCT_SCALE;
      rhs = {33'h000000000, target_mean} * `AEWB_FULL_SCALE;
    end else begin
      lhs = {12'h000, sum_q} * `AEWB_PCT_SCALE;
      rhs = {33'h000000000, target_mean} * `AEWB_FULL_SCALE *
        {20'h00000, count_q};
    end
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      brighter_out <= 1'b0;
      darker_out <= 1'b0;
    end else if (frame_end_in) begin
      brighter_out <= (count_q != 20'h00000) && (lhs < rhs);
      darker_out <= (count_q != 20'h00000) && (lhs > rhs);
    end
  end

  // White balance: damped step toward profile goal, once a frame
  always @* begin
    if (wb_profile_select_q) begin
      red_goal = wb_outdoor_red_in;
      blue_goal = wb_outdoor_blue_in;
    end else begin
      red_goal = wb_indoor_red_in;
      blue_goal = wb_indoor_blue_in;
    end
  end

  aewb_step u_red_step (
    .current_in(red_q),
    .goal_in(red_goal),
    .damping_in(wb_step_damping_q),
    .next_out(red_next)
  );

  aewb_step u_blue_step (
    .current_in(blue_q),
    .goal_in(blue_goal),
    .damping_in(wb_step_damping_q),
    .next_out(blue_next)
  );

  aewb_clamp #(
    .WIDTH(`AEWB_RATIO_W),
    .RESET_VALUE(`AEWB_RST_WB_RATIO)
  ) u_red_clamp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(frame_end_in && auto_wb_loop_q),
    .value_in(red_next),
    .lo_in(wb_ratio_min_q),
    .hi_in(wb_ratio_max_q),
    .value_out(red_q)
  );

  aewb_clamp #(
    .WIDTH(`AEWB_RATIO_W),
    .RESET_VALUE(`AEWB_RST_WB_RATIO)
  ) u_blue_clamp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(frame_end_in && auto_wb_loop_q),
    .value_in(blue_next),
    .lo_in(wb_ratio_min_q),
    .hi_in(wb_ratio_max_q),
    .value_out(blue_q)
  );

  assign red_ratio_out = red_q;
  assign blue_ratio_out = blue_q;

endmodule // aewb_limits

// Damped step: moves by (goal - current) >> damping, at least one code unless already at the goal.
module aewb_step (
  input wire [`AEWB_RATIO_W-1:0] current_in,
  input wire [`AEWB_RATIO_W-1:0] goal_in,
  input wire [2:0] damping_in,
  output reg [`AEWB_RATIO_W-1:0] next_out
);

  reg [`AEWB_RATIO_W-1:0] delta;
  reg [`AEWB_RATIO_W-1:0] step;

  always @* begin
    if (goal_in >= current_in) begin
      delta = goal_in - current_in;
    end else begin
      delta = current_in - goal_in;
    end
    step = delta >> damping_in;
    if (step == {`AEWB_RATIO_W{1'b0}} && delta != {`AEWB_RATIO_W{1'b0}}) begin
      step = {{(`AEWB_RATIO_W-1){1'b0}}, 1'b1};
    end
    if (goal_in >= current_in) begin
      next_out = current_in + step;
    end else begin
      next_out = current_in - step;
    end
  end

endmodule // aewb_step

`default_nettype wire

// *** rtl/aewb_map.vh ***
// Register offsets, field positions, reset values and metering windows
// for the auto exposure and white balance limit block.
// Assumes an 8-bit word-aligned register address and 32-bit data.
`ifndef AEWB_MAP_VH
`define AEWB_MAP_VH

`define AEWB_REG_CTRL 8'h00
`define AEWB_REG_LIGHTING 8'h04
`define AEWB_REG_METERING 8'h08
`define AEWB_REG_EXP_MIN 8'h0c
`define AEWB_REG_EXP_MAX 8'h10
`define AEWB_REG_GAIN_MIN 8'h14
`define AEWB_REG_GAIN_MAX 8'h18
`define AEWB_REG_TMEAN_MIN 8'h1c
`define AEWB_REG_TMEAN_MAX 8'h20
`define AEWB_REG_TMEAN_VALUE 8'h24
`define AEWB_REG_WB_MIN 8'h28
`define AEWB_REG_WB_MAX 8'h2c
`define AEWB_REG_WB_DAMP 8'h30
`define AEWB_REG_REGION_H 8'h34
`define AEWB_REG_STATUS 8'h38
`define AEWB_REG_EXPOSURE 8'h3c
`define AEWB_REG_GAIN 8'h40
`define AEWB_REG_WB_RATIO 8'h44

// Control register fields
`define AEWB_CTRL_WB_ENABLE 0
`define AEWB_CTRL_TMEAN_SRC 1
`define AEWB_CTRL_PROFILE 2
`define AEWB_CTRL_ALGO_SEL 3

// Widths
`define AEWB_EXP_W 24
`define AEWB_GAIN_W 10
`define AEWB_PCT_W 7
`define AEWB_RATIO_W 12
`define AEWB_HEIGHT_W 12
`define AEWB_POS_W 10

// Lighting codes
`define AEWB_LIGHT_DETECT 2'h0
`define AEWB_LIGHT_BACK 2'h1
`define AEWB_LIGHT_FRONT 2'h2
`define AEWB_LIGHT_NORMAL 2'h3

// Metering codes
`define AEWB_METER_AVERAGE 3'h0
`define AEWB_METER_SPOT 3'h1
`define AEWB_METER_PARTIAL 3'h2
`define AEWB_METER_CENTER 3'h3
`define AEWB_METER_HIST 3'h4

// Reset values
`define AEWB_RST_EXP_MIN 24'h00000f
`define AEWB_RST_EXP_MAX 24'h0f4240
`define AEWB_RST_GAIN_MIN 10'h000
`define AEWB_RST_GAIN_MAX 10'h1e0
`define AEWB_RST_TMEAN_MIN 7'h0a
`define AEWB_RST_TMEAN_MAX 7'h5a
`define AEWB_RST_TMEAN_VALUE 7'h32
`define AEWB_RST_TMEAN_AUTO 7'h32
`define AEWB_RST_WB_MIN 12'h040
`define AEWB_RST_WB_MAX 12'h400
`define AEWB_RST_WB_RATIO 12'h100
`define AEWB_RST_WB_DAMP 3'h2
`define AEWB_RST_REGION_H 12'h1e0

// Frame geometry and centred metering windows (inclusive bounds)
`define AEWB_FRAME_W 640
`define AEWB_FRAME_H 480
`define AEWB_SPOT_X_LO 10'd265
`define AEWB_SPOT_X_HI 10'd374
`define AEWB_SPOT_Y_LO 10'd199
`define AEWB_SPOT_Y_HI 10'd280
`define AEWB_PART_X_LO 10'd215
`define AEWB_PART_X_HI 10'd424
`define AEWB_PART_Y_LO 10'd161
`define AEWB_PART_Y_HI 10'd318

// Full-scale pixel code times percent scale
`define AEWB_FULL_SCALE 8'hff
`define AEWB_PCT_SCALE 7'd100

`endif

// *** rtl/aewb_clamp.v ***
// Registered clamp of a value into an inclusive [lo, hi] range.
// Assumes lo <= hi; with inverted limits the result is not defined.
`default_nettype none

module aewb_clamp #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clock_in,
  input wire reset_in,
  input wire load_in,
  input wire [WIDTH-1:0] value_in,
  input wire [WIDTH-1:0] lo_in,
  input wire [WIDTH-1:0] hi_in,
  output wire [WIDTH-1:0] value_out
);

  reg [WIDTH-1:0] value_q;
  reg [WIDTH-1:0] value_d;

  always @* begin
    if (value_in < lo_in) begin
      value_d = lo_in;
    end else if (value_in > hi_in) begin
      value_d = hi_in;
    end else begin
      value_d = value_in;
    end
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      value_q <= RESET_VALUE;
    end else if (load_in) begin
      value_q <= value_d;
    end
  end

  assign value_out = value_q;

endmodule // aewb_clamp

`default_nettype wire

// *** verif/aewb_limits_checker.sv ***
// Checker for the limit block: clamp, target, ratio and read-port timing.
// Assumes software keeps each minimum at or below its maximum.
`default_nettype none
`include "aewb_map.vh"
module aewb_limits_checker (
  input wire clock_in,
  input wire reset_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [31:0] reg_rdata_out,
  input wire [23:0] exp_request_in,
  input wire [9:0] gain_request_in,
  input wire frame_end_in,
  input wire [23:0] exposure_out,
  input wire [9:0] gain_out,
  input wire [6:0] target_mean_out,
  input wire brighter_out,
  input wire darker_out,
  input wire [11:0] red_ratio_out,
  input wire [11:0] blue_ratio_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Shadow copies of the limits
  logic [23:0] emin_q, emax_q;
  logic [9:0] gmin_q, gmax_q;
  logic [6:0] tmin_q, tmax_q;
  logic [11:0] wmin_q, wmax_q;
  logic wben_q;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      emin_q <= `AEWB_RST_EXP_MIN;
      emax_q <= `AEWB_RST_EXP_MAX;
      gmin_q <= `AEWB_RST_GAIN_MIN;
      gmax_q <= `AEWB_RST_GAIN_MAX;
      tmin_q <= `AEWB_RST_TMEAN_MIN;
      tmax_q <= `AEWB_RST_TMEAN_MAX;
      wmin_q <= `AEWB_RST_WB_MIN;
      wmax_q <= `AEWB_RST_WB_MAX;
      wben_q <= 1'b0;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        `AEWB_REG_CTRL: wben_q <= reg_wdata_in[0];
        `AEWB_REG_EXP_MIN: emin_q <= reg_wdata_in[23:0];
        `AEWB_REG_EXP_MAX: emax_q <= reg_wdata_in[23:0];
        `AEWB_REG_GAIN_MIN: gmin_q <= reg_wdata_in[9:0];
        `AEWB_REG_GAIN_MAX: gmax_q <= reg_wdata_in[9:0];
        `AEWB_REG_TMEAN_MIN: tmin_q <= reg_wdata_in[6:0];
        `AEWB_REG_TMEAN_MAX: tmax_q <= reg_wdata_in[6:0];
        `AEWB_REG_WB_MIN: wmin_q <= reg_wdata_in[11:0];
        `AEWB_REG_WB_MAX: wmax_q <= reg_wdata_in[11:0];
        default: ;
      endcase
    end
  end
  exp_floor_a: assert property (!$past(reset_in) &&
    $past(exp_request_in) < $past(emin_q) |-> exposure_out == $past(emin_q))
    else $error("exposure below minimum");
  exp_ceil_a: assert property (!$past(reset_in) &&
    $past(exp_request_in) > $past(emax_q) |-> exposure_out == $past(emax_q))
    else $error("exposure above maximum");
  gain_floor_a: assert property (!$past(reset_in) &&
    $past(gain_request_in) < $past(gmin_q) |-> gain_out == $past(gmin_q))
    else $error("gain below minimum");
  gain_ceil_a: assert property (!$past(reset_in) &&
    $past(gain_request_in) > $past(gmax_q) |-> gain_out == $past(gmax_q))
    else $error("gain above maximum");
  tmean_floor_a: assert property (!$past(reset_in)
    |-> target_mean_out >= $past(tmin_q)) else $error("target too low");
  tmean_ceil_a: assert property (!$past(reset_in)
    |-> target_mean_out <= $past(tmax_q)) else $error("target too high");
  ratio_floor_a: assert property (!$past(reset_in) &&
    $past(frame_end_in && wben_q) |-> red_ratio_out >= $past(wmin_q) &&
    blue_ratio_out >= $past(wmin_q)) else $error("ratio below minimum");
  ratio_ceil_a: assert property (!$past(reset_in) &&
    $past(frame_end_in && wben_q) |-> red_ratio_out <= $past(wmax_q) &&
    blue_ratio_out <= $past(wmax_q)) else $error("ratio above maximum");
  ratio_hold_a: assert property (!$past(reset_in) &&
    !$past(frame_end_in) |-> $stable(red_ratio_out) &&
    $stable(blue_ratio_out)) else $error("ratio moved between frames");
  sense_excl_a: assert property (!(brighter_out && darker_out))
    else $error("brighter and darker together");
  rdata_idle_a: assert property (!$past(reset_in) && !$past(reg_read_in)
    |-> reg_rdata_out == 32'h0) else $error("read data outside its cycle");
  cover property (frame_end_in && wben_q);
  cover property (exp_request_in > emax_q);
  cover property (brighter_out);
endmodule // aewb_limits_checker
bind aewb_limits aewb_limits_checker u_aewb_limits_checker (.clock_in,
  .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
  .reg_rdata_out, .exp_request_in, .gain_request_in, .frame_end_in,
  .exposure_out, .gain_out, .target_mean_out, .brighter_out, .darker_out,
  .red_ratio_out, .blue_ratio_out);
`default_nettype wire

// *** verif/aewb_limits_tb.sv ***
// Self-checking bench for the limit block, driven over its register port.
// Assumes reads answer one cycle later and the block never stalls.
`default_nettype none
`include "aewb_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, reset_in = 1, reg_write_in = 0, reg_read_in = 0;
  logic pixel_valid_in = 0, frame_end_in = 0, rd_seen = 0;
  logic [7:0] reg_addr_in = 0, pixel_in = 0;
  logic [31:0] reg_wdata_in = 0, lfsr_q = 32'h877d;
  logic [31:0] exp_q[$];
  logic [23:0] exp_request_in = 0;
  logic [9:0] gain_request_in = 0, pixel_x_in = 0, pixel_y_in = 0;
  logic [11:0] wb_indoor_red_in = 12'h200, wb_indoor_blue_in = 12'h080;
  logic [11:0] wb_outdoor_red_in = 12'h300, wb_outdoor_blue_in = 12'h3f0;
  wire [31:0] reg_rdata_out;
  wire [23:0] exposure_out;
  wire [9:0] gain_out;
  wire [6:0] target_mean_out;
  wire brighter_out, darker_out;
  wire [11:0] red_ratio_out, blue_ratio_out;
  wire [11:0] ae_region_height_out, wb_region_height_out;
  int fail_count = 0, tests_run = 0;
  // Outside all windows x3, partial only, spot
  logic [9:0] px[5] = '{10, 20, 30, 220, 300};
  logic [9:0] py[5] = '{10, 10, 10, 170, 240};
  logic [7:0] pv[5] = '{255, 255, 255, 255, 0};
  logic [6:0] tv[5] = '{10, 20, 80, 90, 60};
  logic [1:0] lm[4] = '{1, 2, 0, 3};
  logic [1:0] lw[4] = '{2, 0, 2, 1};
  aewb_limits u_aewb_limits (.clock_in, .reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .exp_request_in, .gain_request_in, .pixel_valid_in, .pixel_in,
    .pixel_x_in, .pixel_y_in, .frame_end_in, .wb_indoor_red_in,
    .wb_indoor_blue_in, .wb_outdoor_red_in, .wb_outdoor_blue_in,
    .exposure_out, .gain_out, .target_mean_out, .brighter_out,
    .darker_out, .red_ratio_out, .blue_ratio_out, .ae_region_height_out,
    .wb_region_height_out);
  initial forever #4 clock_in = ~clock_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction
  function automatic logic [31:0] clampv(input logic [31:0] v, lo, hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_write_in <= 1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_write_in <= 0;
  endtask
  // Expected value queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clock_in);
    reg_read_in <= 1;
    reg_addr_in <= a;
    exp_q.push_back(want);
    @(posedge clock_in);
    reg_read_in <= 0;
  endtask
  task automatic settle();
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  task automatic frame(input logic [2:0] m, input logic [1:0] want);
    wr(`AEWB_REG_METERING, m);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_in);
      pixel_valid_in <= 1;
      pixel_x_in <= px[i];
      pixel_y_in <= py[i];
      pixel_in <= pv[i];
    end
    @(posedge clock_in);
    pixel_valid_in <= 0;
    frame_end_in <= 1;
    @(posedge clock_in);
    frame_end_in <= 0;
    settle();
    chk({darker_out, brighter_out}, want);
  endtask
  always @(posedge clock_in) begin
    rd_seen <= reg_read_in;
    if (rd_seen) chk(reg_rdata_out, exp_q.pop_front());
  end
  initial begin
    repeat (30000) @(posedge clock_in);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clock_in);
    reset_in <= 0;
    rd(`AEWB_REG_LIGHTING, `AEWB_LIGHT_NORMAL);
    rd(`AEWB_REG_METERING, `AEWB_METER_AVERAGE);
    rd(`AEWB_REG_EXP_MIN, `AEWB_RST_EXP_MIN);
    rd(`AEWB_REG_EXP_MAX, `AEWB_RST_EXP_MAX);
    rd(`AEWB_REG_WB_RATIO, 32'h01000100);
    rd(8'h48, 0);
    chk({ae_region_height_out, wb_region_height_out}, 24'h1e01e0);
    wr(`AEWB_REG_EXP_MIN, 100);
    wr(`AEWB_REG_EXP_MAX, 1000);
    wr(`AEWB_REG_GAIN_MIN, 10);
    wr(`AEWB_REG_GAIN_MAX, 200);
    for (int i = 0; i < 24; i++) begin
      lfsr_q = lfsr(lfsr(lfsr_q));
      @(posedge clock_in);
      exp_request_in <= {13'h0, lfsr_q[10:0]};
      gain_request_in <= lfsr_q[25:16];
      settle();
      chk(exposure_out, clampv(lfsr_q[10:0], 100, 1000));
      chk(gain_out, clampv(lfsr_q[25:16], 10, 200));
    end
    // Read-only: write ignored
    wr(`AEWB_REG_GAIN, 0);
    rd(`AEWB_REG_GAIN, clampv(lfsr_q[25:16], 10, 200));
    wr(`AEWB_REG_TMEAN_MIN, 20);
    wr(`AEWB_REG_TMEAN_MAX, 80);
    foreach (tv[i]) begin
      wr(`AEWB_REG_TMEAN_VALUE, tv[i]);
      settle();
      chk(target_mean_out, clampv(tv[i], 20, 80));
    end
    wr(`AEWB_REG_CTRL, 2);
    settle();
    chk(target_mean_out, 50);
    wr(`AEWB_REG_CTRL, 0);
    wr(`AEWB_REG_TMEAN_VALUE, 50);
    for (int m = 0; m < 6; m++) begin
      wr(`AEWB_REG_METERING, m);
      rd(`AEWB_REG_METERING, m < 5 ? m : 4);
    end
    frame(`AEWB_METER_AVERAGE, 2);
    frame(`AEWB_METER_SPOT, 1);
    frame(`AEWB_METER_PARTIAL, 0);
    foreach (lm[i]) begin
      wr(`AEWB_REG_LIGHTING, lm[i]);
      frame(`AEWB_METER_SPOT, lw[i]);
    end
    frame(`AEWB_METER_HIST, 2);
    wr(`AEWB_REG_CTRL, 1);
    frame(0, 2);
    chk({red_ratio_out, blue_ratio_out}, 24'h1400e0);
    wr(`AEWB_REG_WB_DAMP, 3);
    frame(0, 2);
    chk({red_ratio_out, blue_ratio_out}, 24'h1580d4);
    wr(`AEWB_REG_WB_MAX, 12'h160);
    wr(`AEWB_REG_CTRL, 5);
    frame(0, 2);
    chk({red_ratio_out, blue_ratio_out}, 24'h160137);
    wr(`AEWB_REG_WB_MIN, 12'h150);
    wr(`AEWB_REG_CTRL, 1);
    frame(0, 2);
    chk({red_ratio_out, blue_ratio_out}, 24'h160150);
    rd(`AEWB_REG_WB_RATIO, 32'h01500160);
    wr(`AEWB_REG_CTRL, 8);
    wr(`AEWB_REG_REGION_H, 12'h100);
    wr(`AEWB_REG_CTRL, 0);
    wr(`AEWB_REG_REGION_H, 12'h080);
    settle();
    chk(ae_region_height_out, 12'h100);
    chk(wb_region_height_out, 12'h080);
    repeat (3) @(posedge clock_in);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
